// *** core/wic_pkg.sv ***
// Package of constants and types for the wakeup and interrupt control block.
// Notes on behaviour
// RQ1 - Sleep wakes only to normal, pin changes only.
// RQ2 - Green wakes to prior mode, pins or timer.
// RQ3 - Sleep wake waits 2048 oscillator cycles first; the code keeps the core stopped for 2049 clk_sys cycles.
// RQ4 - Green wake resumes at once, no wait.
// RQ5 - Port 0 always wakes; port 1 per bit.
// RQ6 - Serviced interrupt loads vector address eight.
// RQ7 - Entry clears global enable; return sets it.
// RQ8 - Entry pushes one stack level; return pops.
// RQ9 - Enables: pin bit 0, timer 4, counter 5.
// RQ10 - Flags at same bits, sticky until cleared.
// RQ11 - Global enable is stack bit 7, resets 0.
// RQ12 - Pin event sets flag regardless of enable.
// RQ13 - Timer overflow sets flag regardless of enable.
// RQ14 - Edge field: reserved, rising, falling, both.
// RQ15 - One-level save buffer, status bits excluded.
// RQ16 - Software waits half clock before timer clear.
// RQ17 - Software keeps timer count in clock mode.
// RQ18 - Counter overflow sets flag regardless of enable.
// RQ19 - Sleep wake clears the sleep request bit.
// RQ20 - One vector request from any enabled pending.
package wic_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_EDGE = 8'hBF;
    localparam logic [7:0] IDX_P1W = 8'hC0;
    localparam logic [7:0] IDX_FLAGS = 8'hC8;
    localparam logic [7:0] IDX_EN = 8'hC9;
    localparam logic [7:0] IDX_STACK_POINTER_AND_GLOBAL_ENABLE = 8'hDF;

    localparam logic [7:0] RST_EDGE = 8'h10;
    localparam logic [7:0] RST_P1W = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_EN = 8'h00;
    localparam logic [7:0] RST_STACK_POINTER_AND_GLOBAL_ENABLE = 8'h03;

    localparam int unsigned BIT_PIN = 0;
    localparam int unsigned BIT_T0 = 4;
    localparam int unsigned BIT_TC0 = 5;
    localparam int unsigned BIT_GIE = 7;
    localparam int unsigned EDGE_LO = 3;
    localparam int unsigned P1_PINS = 4;
    localparam logic [7:0] IRQ_MASK = 8'h31;
    localparam logic [7:0] EDGE_MASK = 8'h18;
    localparam logic [7:0] P1W_MASK = 8'h0F;
    localparam logic [1:0] SP_RST = 2'h3;

    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    localparam logic [11:0] VECTOR_ADDR = 12'h008;
    // Timeout and power-down status bits of the flag register.
    localparam logic [7:0] FLAG_NOSAVE = 8'h0C;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // The high-speed oscillator is taken as clk_sys itself.
    localparam int unsigned WAKE_OSC_CYCLES = 2048;
    localparam int unsigned CLK_PER_OSC = 1;
    localparam int unsigned SETTLE_CYCLES = WAKE_OSC_CYCLES * CLK_PER_OSC;
    localparam int unsigned CNT_W = 12;
    localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYCLES - 1);

    typedef enum logic [3:0] {
        PWR_RUN = 4'h1,
        PWR_SLEEP = 4'h2,
        PWR_GREEN = 4'h4,
        PWR_SETTLE = 4'h8
    } wic_pwr_t;

    typedef struct packed {
        logic t0_ovf;
        logic tc0_ovf;
        logic irq_accept;
        logic irq_return;
        logic sleep_req;
        logic green_req;
        logic save_req;
    } wic_core_ev_t;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] flags;
    } wic_ctx_t;

endpackage

// *** core/wic_settle_cnt.sv ***
// Oscillator settle counter used after a wake from sleep.
`timescale 1ns/1ps
`default_nettype none
module wic_settle_cnt (
    // Clock, reset and freeze.
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // Start pulse in, done pulse out.
    input wire logic start,
    output logic done
);
    logic [wic_pkg::CNT_W-1:0] cnt_reg;
    logic [wic_pkg::CNT_W-1:0] cnt_next;
    logic busy_reg;
    logic busy_next;
    logic done_reg;
    logic done_next;

    always_comb begin
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (start) begin
            cnt_next = wic_pkg::SETTLE_LOAD; // see RQ3
            busy_next = 1'b1;
        end else if (busy_reg) begin
            if (cnt_reg == '0) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (clk_en) begin
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign done = done_reg;
endmodule
`default_nettype wire

// *** core/wic_top.sv ***
// Wakeup and interrupt control with its AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
module wic_top (
    // Clock, reset and freeze.
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Port pins, synchronous to clk_sys.
    input wire logic port0_pin,
    input wire logic [3:0] port1_pins,
    // Core and timer events.
    input wire wic_pkg::wic_core_ev_t core_ev,
    input wire wic_pkg::wic_ctx_t ctx_in,
    input wire logic slow_mode,
    // Core steering.
    output logic vector_req,
    output logic [11:0] vector_addr,
    output logic cpu_run,
    output logic run_slow,
    output logic sleep_request_bit,
    output logic [1:0] stack_level,
    output wic_pkg::wic_ctx_t ctx_out
);

    function automatic logic is_reg(input logic [7:0] idx,
                                    input logic [7:0] code);
        is_reg = (idx == code);
    endfunction

    // Bus phase state.
    logic wr_pend_reg;
    logic wr_pend_next;
    logic [7:0] wr_idx_reg;
    logic [7:0] wr_idx_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;

    // Software registers.
    logic [7:0] edge_reg;
    logic [7:0] edge_next;
    logic [7:0] p1w_reg;
    logic [7:0] p1w_next;
    logic [7:0] en_reg;
    logic [7:0] en_next;
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic gie_reg;
    logic gie_next;
    logic [1:0] sp_reg;
    logic [1:0] sp_next;

    // Pin history.
    logic p0_prev_reg;
    logic p0_prev_next;
    logic [3:0] p1_prev_reg;
    logic [3:0] p1_prev_next;

    // Power state.
    wic_pkg::wic_pwr_t pwr_reg;
    wic_pkg::wic_pwr_t pwr_next;
    logic slow_reg;
    logic slow_next;
    logic green_slow_reg;
    logic green_slow_next;
    logic sleep_bit_reg;
    logic sleep_bit_next;
    logic run_reg;
    logic run_next;
    logic settle_start;
    logic settle_done;

    // Vector and save buffer.
    logic vreq_reg;
    logic vreq_next;
    logic [11:0] vaddr_reg;
    wic_pkg::wic_ctx_t ctx_reg;
    wic_pkg::wic_ctx_t ctx_next;

    logic wr_now;
    logic [7:0] wr_byte;
    logic [3:0] p1_wake;
    logic p0_wake;
    logic pin_wake;
    logic pin_rise;
    logic pin_fall;
    logic pin_event;

    assign wr_now = wr_pend_reg;
    assign wr_byte = hwdata[7:0];

    genvar gi;
    generate
        for (gi = 0; gi < wic_pkg::P1_PINS; gi++) begin : g_p1
            // A port 1 pin wakes only when its enable bit is 1.
            assign p1_wake[gi] = (port1_pins[gi] ^ p1_prev_reg[gi])
                                 & p1w_reg[gi]; // see RQ5
        end
    endgenerate

    assign p0_wake = port0_pin ^ p0_prev_reg; // see RQ5
    assign pin_wake = p0_wake | (|p1_wake);
    assign pin_rise = port0_pin & ~p0_prev_reg;
    assign pin_fall = ~port0_pin & p0_prev_reg;

    // The reserved edge code never triggers, so a stray write stays quiet.
    always_comb begin
        unique case (edge_reg[wic_pkg::EDGE_LO +: 2])
            wic_pkg::EDGE_RISE: pin_event = pin_rise; // see RQ14
            wic_pkg::EDGE_FALL: pin_event = pin_fall; // see RQ14
            wic_pkg::EDGE_BOTH: pin_event = pin_rise | pin_fall;
            default: pin_event = 1'b0;
        endcase
    end

    always_comb begin
        p0_prev_next = port0_pin;
        p1_prev_next = port1_pins;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            p0_prev_reg <= 1'b0;
            p1_prev_reg <= 4'h0;
        end else if (clk_en) begin
            p0_prev_reg <= p0_prev_next;
            p1_prev_reg <= p1_prev_next;
        end
    end

    // Configuration registers.
    always_comb begin
        edge_next = edge_reg;
        p1w_next = p1w_reg;
        en_next = en_reg;
        if (wr_now && is_reg(wr_idx_reg, wic_pkg::IDX_EDGE)) begin
            edge_next = wr_byte & wic_pkg::EDGE_MASK; // see RQ14
        end
        if (wr_now && is_reg(wr_idx_reg, wic_pkg::IDX_P1W)) begin
            p1w_next = wr_byte & wic_pkg::P1W_MASK; // see RQ5
        end
        if (wr_now && is_reg(wr_idx_reg, wic_pkg::IDX_EN)) begin
            en_next = wr_byte & wic_pkg::IRQ_MASK; // see RQ9
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            edge_reg <= wic_pkg::RST_EDGE;
            p1w_reg <= wic_pkg::RST_P1W;
            en_reg <= wic_pkg::RST_EN;
        end else if (clk_en) begin
            edge_reg <= edge_next;
            p1w_reg <= p1w_next;
            en_reg <= en_next;
        end
    end

    // Request flags; an event in the same cycle as a clear wins.
    always_comb begin
        flags_next = flags_reg;
        if (wr_now && is_reg(wr_idx_reg, wic_pkg::IDX_FLAGS)) begin
            flags_next = wr_byte & wic_pkg::IRQ_MASK; // see RQ10
        end
        if (pin_event) begin
            flags_next[wic_pkg::BIT_PIN] = 1'b1; // see RQ12
        end
        if (core_ev.t0_ovf) begin
            flags_next[wic_pkg::BIT_T0] = 1'b1; // see RQ13
        end
        if (core_ev.tc0_ovf) begin
            flags_next[wic_pkg::BIT_TC0] = 1'b1; // see RQ18
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flags_reg <= wic_pkg::RST_FLAGS;
        end else if (clk_en) begin
            flags_reg <= flags_next;
        end
    end

    // Global enable and stack level. Core events take precedence over a
    // bus write in the same cycle, so service entry is never undone.
    always_comb begin
        gie_next = gie_reg;
        sp_next = sp_reg;
        if (wr_now && is_reg(wr_idx_reg, wic_pkg::IDX_STACK_POINTER_AND_GLOBAL_ENABLE)) begin
            gie_next = wr_byte[wic_pkg::BIT_GIE]; // see RQ11
            sp_next = wr_byte[1:0];
        end
        if (core_ev.irq_accept) begin
            gie_next = 1'b0; // see RQ7
            sp_next = sp_reg - 2'h1; // see RQ8
        end else if (core_ev.irq_return) begin
            gie_next = 1'b1; // see RQ7
            sp_next = sp_reg + 2'h1; // see RQ8
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            gie_reg <= wic_pkg::RST_STACK_POINTER_AND_GLOBAL_ENABLE[wic_pkg::BIT_GIE];
            sp_reg <= wic_pkg::SP_RST;
        end else if (clk_en) begin
            gie_reg <= gie_next;
            sp_reg <= sp_next;
        end
    end

    // Power state machine.
    always_comb begin
        pwr_next = pwr_reg;
        slow_next = slow_reg;
        green_slow_next = green_slow_reg;
        sleep_bit_next = sleep_bit_reg;
        settle_start = 1'b0;
        unique case (pwr_reg)
            wic_pkg::PWR_RUN: begin
                slow_next = slow_mode;
                if (core_ev.sleep_req) begin
                    pwr_next = wic_pkg::PWR_SLEEP;
                    sleep_bit_next = 1'b1;
                end else if (core_ev.green_req) begin
                    pwr_next = wic_pkg::PWR_GREEN;
                    green_slow_next = slow_mode;
                end
            end
            wic_pkg::PWR_SLEEP: begin
                // Only pin changes reach here; the timer is stopped.
                if (pin_wake) begin // see RQ1
                    pwr_next = wic_pkg::PWR_SETTLE;
                    settle_start = 1'b1; // see RQ3
                    sleep_bit_next = 1'b0; // see RQ19
                    slow_next = 1'b0; // see RQ1
                end
            end
            wic_pkg::PWR_SETTLE: begin
                if (settle_done) begin
                    pwr_next = wic_pkg::PWR_RUN; // see RQ3
                end
            end
            wic_pkg::PWR_GREEN: begin
                if (pin_wake || core_ev.t0_ovf) begin // see RQ2
                    pwr_next = wic_pkg::PWR_RUN; // see RQ4
                    slow_next = green_slow_reg; // see RQ2
                end
            end
            default: begin
                pwr_next = wic_pkg::PWR_RUN;
            end
        endcase
        run_next = (pwr_next == wic_pkg::PWR_RUN);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pwr_reg <= wic_pkg::PWR_RUN;
            slow_reg <= 1'b0;
            green_slow_reg <= 1'b0;
            sleep_bit_reg <= 1'b0;
            run_reg <= 1'b1;
        end else if (clk_en) begin
            pwr_reg <= pwr_next;
            slow_reg <= slow_next;
            green_slow_reg <= green_slow_next;
            sleep_bit_reg <= sleep_bit_next;
            run_reg <= run_next;
        end
    end

    wic_settle_cnt u_settle (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .start(settle_start),
        .done(settle_done)
    );

    // Vector request and save buffer. Priority among sources is left to
    // the service routine; the block only says that something is due.
    always_comb begin
        vreq_next = gie_next && run_next
                    && |(flags_next & en_next & wic_pkg::IRQ_MASK); // see RQ20
        ctx_next = ctx_reg;
        if (core_ev.save_req) begin
            ctx_next.acc = ctx_in.acc; // see RQ15
            ctx_next.flags = ctx_in.flags & ~wic_pkg::FLAG_NOSAVE;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            vreq_reg <= 1'b0;
            vaddr_reg <= wic_pkg::VECTOR_ADDR;
            ctx_reg <= '0;
        end else if (clk_en) begin
            vreq_reg <= vreq_next; // see RQ11
            vaddr_reg <= wic_pkg::VECTOR_ADDR; // see RQ6
            ctx_reg <= ctx_next;
        end
    end

    // Bus slave. Read data come from the values after any write in the
    // same cycle, so a read right after a write sees the new value; the port 1 wake register always reads as zero.
    always_comb begin
        logic take;
        logic [7:0] idx;
        logic [7:0] rv;
        take = hsel && htrans[1] && hready;
        idx = haddr[9:2];
        rv = 8'h00;
        wr_pend_next = take && hwrite && (hsize == wic_pkg::HSIZE_WORD);
        wr_idx_next = idx;
        hrdata_next = hrdata_reg;
        if (take && !hwrite) begin
            if (is_reg(idx, wic_pkg::IDX_EDGE)) begin
                rv = edge_next;
            end else if (is_reg(idx, wic_pkg::IDX_FLAGS)) begin
                rv = flags_next;
            end else if (is_reg(idx, wic_pkg::IDX_EN)) begin
                rv = en_next;
            end else if (is_reg(idx, wic_pkg::IDX_STACK_POINTER_AND_GLOBAL_ENABLE)) begin
                rv = {gie_next, 5'h00, sp_next};
            end
            hrdata_next = {24'h000000, rv};
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 8'h00;
            hrdata_reg <= 32'h00000000;
        end else if (clk_en) begin
            wr_pend_reg <= wr_pend_next;
            wr_idx_reg <= wr_idx_next;
            hrdata_reg <= hrdata_next;
        end
    end

    // Zero wait states: the slave is always ready and always OKAY.
    logic hready_reg;
    logic hresp_reg;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hready_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end else if (clk_en) begin
            hready_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end
    end

    assign hreadyout = hready_reg;
    assign hresp = hresp_reg;
    assign hrdata = hrdata_reg;
    assign vector_req = vreq_reg;
    assign vector_addr = vaddr_reg;
    assign cpu_run = run_reg;
    assign run_slow = slow_reg;
    assign sleep_request_bit = sleep_bit_reg;
    assign stack_level = sp_reg;
    assign ctx_out = ctx_reg;

endmodule
`default_nettype wire

// *** dv/wic_top_monitor.sv ***
// Port checker for the wakeup and interrupt block.
`timescale 1ns/1ps
`default_nettype none
module wic_top_monitor (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // Core side.
    input wire wic_pkg::wic_core_ev_t core_ev,
    input wire logic vector_req,
    input wire logic [11:0] vector_addr,
    input wire logic cpu_run,
    input wire logic sleep_request_bit,
    input wire logic [1:0] stack_level
);
    logic [11:0] wcnt_reg, wcnt_next;
    logic slp_reg, slp_next, grn;
    // Green is told from settling by remembering that sleep came first.
    assign grn = !cpu_run && !sleep_request_bit && !slp_reg;
    always_comb begin
        wcnt_next = wcnt_reg + 12'h001;
        if (sleep_request_bit || cpu_run) begin
            wcnt_next = 12'h000;
        end
        slp_next = sleep_request_bit || (slp_reg && !cpu_run);
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wcnt_reg <= 12'h000;
            slp_reg <= 1'b0;
        end else if (clk_en) begin
            wcnt_reg <= wcnt_next;
            slp_reg <= slp_next;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    a_vec_addr: assert property (vector_addr == 12'h008)
        else $error("vector address wrong");
    a_push_level: assert property (core_ev.irq_accept &&
        !core_ev.irq_return && clk_en |=>
        stack_level == $past(stack_level) - 2'h1)
        else $error("push did not lower the stack level");
    a_pop_level: assert property (core_ev.irq_return &&
        !core_ev.irq_accept && clk_en |=>
        stack_level == $past(stack_level) + 2'h1)
        else $error("pop did not raise the stack level");
    a_accept_gie: assert property (core_ev.irq_accept ##1
        !core_ev.irq_return |=> !vector_req)
        else $error("vector request survived entry");
    a_sleep_entry: assert property (cpu_run && core_ev.sleep_req &&
        clk_en |=> sleep_request_bit && !cpu_run)
        else $error("sleep not entered");
    a_sleep_halt: assert property (sleep_request_bit |-> !cpu_run)
        else $error("running while asleep");
    a_settle_len: assert property ($rose(cpu_run) && slp_reg |->
        wcnt_reg == 12'h801)
        else $error("settle wait length wrong");
    a_green_wake: assert property (grn && core_ev.t0_ovf &&
        clk_en |=> cpu_run)
        else $error("green wake not immediate");
    c_sleep_wake: cover property ($rose(cpu_run) && slp_reg);
    c_green_wake: cover property (grn && core_ev.t0_ovf);
    c_vector: cover property ($rose(vector_req));
endmodule
bind wic_top wic_top_monitor u_mon (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .core_ev(core_ev),
    .vector_req(vector_req),
    .vector_addr(vector_addr),
    .cpu_run(cpu_run),
    .sleep_request_bit(sleep_request_bit),
    .stack_level(stack_level)
);
`default_nettype wire

// *** dv/wic_core_model.sv ***
// Behavioural model of the processor core taking and leaving the vector.
`timescale 1ns/1ps
`default_nettype none
module wic_core_model (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // Block outputs.
    input wire logic vector_req,
    input wire logic cpu_run,
    // Accept latency and return command.
    input wire logic [3:0] lat,
    input wire logic ret_go,
    // Core pulses.
    output logic irq_accept,
    output logic irq_return
);
    logic [3:0] cnt_reg, cnt_next;
    logic busy_reg, busy_next, acc_next, ret_next;
    always_comb begin
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        acc_next = 1'b0;
        ret_next = 1'b0;
        // A slow core lets the request wait lat cycles before taking it.
        if (!busy_reg && vector_req && cpu_run) begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == lat) begin
                cnt_next = 4'h0;
                busy_next = 1'b1;
                acc_next = 1'b1;
            end
        end
        // Service ends late and never reloads the timer.
        if (busy_reg && ret_go) begin
            busy_next = 1'b0;
            ret_next = 1'b1;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 4'h0;
            busy_reg <= 1'b0;
            irq_accept <= 1'b0;
            irq_return <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            irq_accept <= acc_next;
            irq_return <= ret_next;
        end
    end
endmodule
`default_nettype wire

// *** dv/wic_bench.sv ***
// Self-checking bench for the wakeup and interrupt block.
`timescale 1ns/1ps
`default_nettype none
module wic_bench;
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } wic_row_t;
    logic clk_sys, arst_n, hsel, hwrite, hreadyout, hresp, port0_pin;
    logic slow_mode, vector_req, cpu_run, run_slow, sleep_request_bit;
    logic acc, ret, ret_go, clk_en;
    logic [1:0] htrans, stack_level;
    logic [2:0] hsize;
    logic [3:0] port1_pins, lat;
    logic [6:0] ev;
    logic [11:0] vector_addr;
    logic [31:0] haddr, hwdata, hrdata, rd;
    wic_pkg::wic_ctx_t ctx_in, ctx_out;
    wic_pkg::wic_core_ev_t core_ev;
    int errors, compares, n;
    wic_row_t rows [14] = '{'{0, 12'h2FC, 0, 8'h10}, '{0, 12'h37C, 0, 8'h03},
        '{0, 12'h320, 0, 0}, '{0, 12'h324, 0, 0}, '{0, 12'h300, 0, 0},
        '{1, 12'h2FC, 8'hFF, 8'h18}, '{1, 12'h324, 8'hFF, 8'h31},
        '{1, 12'h320, 8'hFF, 8'h31}, '{1, 12'h320, 0, 0},
        '{1, 12'h324, 0, 0}, '{1, 12'h300, 8'h0F, 0},
        '{1, 12'h100, 8'hFF, 0}, '{1, 12'h37C, 8'h83, 8'h83},
        '{1, 12'h37C, 8'h03, 8'h03}};
    assign core_ev = wic_pkg::wic_core_ev_t'(ev | {2'h0, acc, ret, 3'h0});
    wic_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .port0_pin(port0_pin), .port1_pins(port1_pins), .core_ev(core_ev),
        .ctx_in(ctx_in), .slow_mode(slow_mode), .vector_req(vector_req),
        .vector_addr(vector_addr), .cpu_run(cpu_run), .run_slow(run_slow),
        .sleep_request_bit(sleep_request_bit), .stack_level(stack_level),
        .ctx_out(ctx_out));
    wic_core_model model (.clk_sys(clk_sys), .arst_n(arst_n),
        .vector_req(vector_req), .cpu_run(cpu_run), .lat(lat),
        .ret_go(ret_go), .irq_accept(acc), .irq_return(ret));
    task automatic chk(input string s, input logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, logic [7:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h00000, a};
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h000000, d};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic pulse(input logic [6:0] b);
        @(posedge clk_sys);
        ev <= b;
        @(posedge clk_sys);
        ev <= 7'h00;
        #1;
    endtask
    task automatic end_sim;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // The longest wait is the 2049-cycle settle; the rest is short.
    initial begin
        repeat (12000) @(posedge clk_sys);
        errors++;
        end_sim();
    end
    initial begin
        {hsel, hwrite, port0_pin, slow_mode, ret_go, arst_n} = 6'h00;
        clk_en = 1'b1;
        {htrans, haddr, hwdata, port1_pins, ev, lat, ctx_in} = '0;
        hsize = wic_pkg::HSIZE_WORD;
        errors = 0;
        compares = 0;
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        #1 chk("reset", {hreadyout, hresp, vector_req, cpu_run,
            sleep_request_bit, stack_level}, 7'h4B);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 8'h00);
            chk("reg", rd, rows[i].e);
        end
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, 12'h2FC, {3'h0, c[1:0], 3'h0});
            bus(1'b1, 12'h320, 8'h00);
            port0_pin <= 1'b1;
            bus(1'b0, 12'h320, 8'h00);
            chk("rise", rd, c[0]);
            bus(1'b1, 12'h320, 8'h00);
            port0_pin <= 1'b0;
            bus(1'b0, 12'h320, 8'h00);
            chk("fall", rd, c[1]);
        end
        bus(1'b1, 12'h37C, 8'h83);
        pulse(7'h60);
        bus(1'b0, 12'h320, 8'h00);
        chk("flags", rd, 8'h31);
        chk("masked", vector_req, 1'b0);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, 12'h320, 8'h00);
            lat <= k ? 4'h5 : 4'h0;
            pulse(7'h40);
            bus(1'b1, 12'h324, 8'h10);
            #1 chk("pending", vector_req, 1'b1);
            for (n = 0; n < 40 && stack_level !== 2'h2; n++) begin
                @(posedge clk_sys);
            end
            chk("vector", vector_addr, 12'h008);
            bus(1'b0, 12'h37C, 8'h00);
            chk("entry", rd, 8'h02);
            bus(1'b1, 12'h324, 8'h00);
            ret_go <= 1'b1;
            @(posedge clk_sys);
            ret_go <= 1'b0;
            bus(1'b0, 12'h37C, 8'h00);
            chk("exit", rd, 8'h83);
        end
        ctx_in <= '{acc: 8'hA5, flags: 8'hFF};
        pulse(7'h01);
        chk("save", ctx_out, 16'hA5F3);
        bus(1'b1, 12'h300, 8'h01);
        slow_mode <= 1'b1;
        pulse(7'h04);
        chk("sleep", {sleep_request_bit, cpu_run}, 2'h2);
        port1_pins <= 4'h2;
        pulse(7'h40);
        repeat (3) @(posedge clk_sys);
        #1 chk("asleep", {sleep_request_bit, cpu_run}, 2'h2);
        @(posedge clk_sys);
        port1_pins <= 4'h3;
        @(posedge clk_sys);
        #1 chk("woke", {sleep_request_bit, cpu_run, run_slow}, 0);
        for (n = 0; n < 3000 && cpu_run !== 1'b1; n++) @(posedge clk_sys) #1;
        chk("settle", n, 2049);
        pulse(7'h02);
        chk("green", cpu_run, 1'b0);
        pulse(7'h40);
        chk("slow back", {cpu_run, run_slow}, 2'h3);
        slow_mode <= 1'b0;
        pulse(7'h02);
        port0_pin <= 1'b1;
        @(posedge clk_sys);
        #1 chk("pin wake", {cpu_run, run_slow}, 2'h2);
        clk_en <= 1'b0;
        pulse(7'h04);
        chk("frozen", {sleep_request_bit, cpu_run}, 2'h1);
        clk_en <= 1'b1;
        @(posedge clk_sys);
        arst_n <= 1'b0;
        @(posedge clk_sys);
        arst_n <= 1'b1;
        bus(1'b0, 12'h37C, 8'h00);
        chk("rereset", rd, 8'h03);
        end_sim();
    end
endmodule
`default_nettype wire
